// file: rtl/fze_defs.vh
// Constants for the zero-divide, denormal and overflow exception unit.
// Included by every design file; holds definitions only.
`ifndef FZE_DEFS_VH
`define FZE_DEFS_VH

// Status and control word bit positions
`define FZE_DE_BIT       1
`define FZE_ZE_BIT       2
`define FZE_OE_BIT       3
`define FZE_C1_BIT       9
`define FZE_SW_RESET     16'h0000

// Operation codes presented by the datapath
`define FZE_OP_W         4
`define FZE_OP_NONE      4'h0
`define FZE_OP_DIV       4'h1
`define FZE_OP_DIVP      4'h2
`define FZE_OP_RDIV      4'h3
`define FZE_OP_RDIVP     4'h4
`define FZE_OP_IDIV      4'h5
`define FZE_OP_IRDIV     4'h6
`define FZE_OP_LOG       4'h7
`define FZE_OP_XTRACT    4'h8
`define FZE_OP_SCALE     4'h9
`define FZE_OP_STORE     4'ha
`define FZE_OP_STOREP    4'hb
`define FZE_OP_ARITH     4'hc
`define FZE_OP_LOAD      4'hd

// Destination formats
`define FZE_FMT_EXT      2'h0
`define FZE_FMT_SGL      2'h1
`define FZE_FMT_DBL      2'h2
`define FZE_FMT_INT      2'h3

// Rounding modes
`define FZE_RND_NEAR     2'h0
`define FZE_RND_DOWN     2'h1
`define FZE_RND_UP       2'h2
`define FZE_RND_ZERO     2'h3

// Extended exponent field: bias 16383, 15 bits
`define FZE_EXP_W        15
`define FZE_EXP_MAX      15'h7fff
`define FZE_EXP_INF      15'h7fff
`define FZE_EXP_BIAS     17'h03fff
// Largest biased exponents at 2^16384, 2^128, 2^1024 limits
`define FZE_LIM_EXT      17'h07ffe
`define FZE_LIM_SGL      17'h0407e
`define FZE_LIM_DBL      17'h043fe
`define FZE_REBIAS       17'h06000
`define FZE_SIG_W        64
`define FZE_SIG_MAXFIN   64'hffffffffffffffff
`define FZE_SIG_INF      64'h8000000000000000

`endif

// file: rtl/fze_flags.v
// Sticky status bits for denormal, zero-divide and overflow plus round-up.
// Assumes event strobes are one-cycle pulses on CLK.
`timescale 1ns/1ps
`include "fze_defs.vh"

module fze_flags (
	input  wire        clk,
	input  wire        reset,
	input  wire        set_de,
	input  wire        set_ze,
	input  wire        set_oe,
	input  wire [2:0]  clr,
	input  wire        c1_we,
	input  wire        c1_val,
	output reg  [15:0] status
);

	// Set wins over software clear in the same cycle
	always @(posedge clk) begin
		if (reset) begin
			status <= `FZE_SW_RESET;
		end else begin
			if (set_de | ~clr[0])
				status[`FZE_DE_BIT] <= status[`FZE_DE_BIT] | set_de;
			else
				status[`FZE_DE_BIT] <= 1'b0;
			if (set_ze | ~clr[1])
				status[`FZE_ZE_BIT] <= status[`FZE_ZE_BIT] | set_ze;
			else
				status[`FZE_ZE_BIT] <= 1'b0;
			if (set_oe | ~clr[2])
				status[`FZE_OE_BIT] <= status[`FZE_OE_BIT] | set_oe;
			else
				status[`FZE_OE_BIT] <= 1'b0;
			if (c1_we)
				status[`FZE_C1_BIT] <= c1_val;
		end
	end

endmodule // fze_flags

// file: rtl/fze_result.v
// Masked default result for overflow.
// Pure combinational; the main module registers the outputs.
`timescale 1ns/1ps
`include "fze_defs.vh"

module fze_result (
	input  wire [1:0]  rnd,
	input  wire        sign,
	output reg         ovf_sign,
	output reg  [14:0] ovf_exp,
	output reg  [63:0] ovf_sig
);

	reg to_max;

	always @* begin
		case (rnd)
		`FZE_RND_DOWN: to_max = ~sign;
		`FZE_RND_UP:   to_max = sign;
		`FZE_RND_ZERO: to_max = 1'b1;
		default:       to_max = 1'b0;
		endcase
		ovf_sign = sign;
		if (to_max) begin
			ovf_exp = `FZE_EXP_MAX - 15'h0001;
			ovf_sig = `FZE_SIG_MAXFIN;
		end else begin
			ovf_exp = `FZE_EXP_INF;
			ovf_sig = `FZE_SIG_INF;
		end
	end

endmodule // fze_result

// file: rtl/fze_unit.v
// Exception unit for zero-divide, denormal operand and numeric overflow.
// Assumes the datapath gives one classified request per START pulse and
// holds its operands steady for that cycle; higher priority faults are
// resolved before a request reaches this block.
// How it works
// - zero-divide when a finite non-zero value is divided by zero
// - zero-divide flag is status bit 2, mask is control bit 2
// - only divides, log product and exponent extract report zero-divide
// - masked divide by zero returns infinity signed by XOR of signs
// - masked log by zero returns infinity opposite the non-zero sign
// - masked extract by zero: second gets minus infinity, top signed zero
// - unmasked zero-divide sets flag, traps, leaves stack and sources
// - denormal on arithmetic use, or single/double load; not extended
// - denormal flag is status bit 1, mask is control bit 1
// - masked denormal sets flag and proceeds, normalizing on conversion
// - unmasked denormal sets flag, traps, leaves stack and sources
// - overflow when rounded result exceeds extended limit 2^16384
// - stores to single or double overflow beyond 2^128 or 2^1024
// - overflowing integer store raises invalid, not overflow
// - overflow flag is status bit 3, mask is control bit 3
// - masked overflow result chosen by rounding mode and sign
// - unmasked memory overflow sets flag, traps, changes nothing
// - unmasked register overflow stores rebiased result, then traps
// - round-up bit tracks rounding direction in rebiased case
// - scale that still overflows after rebias stores signed infinity
// - round-up code bit is status bit 9
`timescale 1ns/1ps
`include "fze_defs.vh"

module fze_unit (
	input  wire        CLK,
	input  wire        RESET,
	input  wire        START,
	input  wire [3:0]  OP,
	input  wire [1:0]  DEST_FMT,
	input  wire        DEST_MEM,
	input  wire [15:0] CONTROL,
	input  wire [2:0]  FLAG_CLEAR,
	input  wire        A_SIGN,
	input  wire        A_ZERO,
	input  wire        A_FINITE,
	input  wire        A_DENORM,
	input  wire        B_SIGN,
	input  wire        B_ZERO,
	input  wire        B_FINITE,
	input  wire        B_DENORM,
	input  wire        R_SIGN,
	input  wire [16:0] R_EXP,
	input  wire [63:0] R_SIG,
	input  wire        R_ROUNDED_UP,
	output reg         DONE,
	output reg         TRAP,
	output reg         INVALID_OPERAND,
	output reg         NORMALIZE,
	output reg         WRITE_TOP,
	output reg         WRITE_SECOND,
	output reg         TOP_SIGN,
	output reg  [14:0] TOP_EXP,
	output reg  [63:0] TOP_SIG,
	output reg         SECOND_SIGN,
	output reg  [14:0] SECOND_EXP,
	output reg  [63:0] SECOND_SIG,
	output wire [15:0] STATUS
);

	// One-hot sequence: idle, store result, raise flags and trap
	localparam ST_IDLE  = 3'b001;
	localparam ST_STORE = 3'b010;
	localparam ST_TRAP  = 3'b100;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg         pend_ze;
	reg         pend_de;
	reg         pend_oe;
	reg         pend_c1;
	reg         pend_c1_val;

	wire        ovf_sign;
	wire [14:0] ovf_exp;
	wire [63:0] ovf_sig;

	// Class decode used by several conditions
	function is_div;
		input [3:0] op;
		begin
			case (op)
			`FZE_OP_DIV, `FZE_OP_DIVP, `FZE_OP_RDIV, `FZE_OP_RDIVP,
			`FZE_OP_IDIV, `FZE_OP_IRDIV:
				is_div = 1'b1;
			default:
				is_div = 1'b0;
			endcase
		end
	endfunction

	function is_arith;
		input [3:0] op;
		begin
			is_arith = is_div(op) || op == `FZE_OP_LOG ||
				op == `FZE_OP_XTRACT || op == `FZE_OP_SCALE ||
				op == `FZE_OP_ARITH;
		end
	endfunction

	function [16:0] limit_of;
		input [1:0] fmt;
		begin
			case (fmt)
			`FZE_FMT_SGL: limit_of = `FZE_LIM_SGL;
			`FZE_FMT_DBL: limit_of = `FZE_LIM_DBL;
			default:      limit_of = `FZE_LIM_EXT;
			endcase
		end
	endfunction

	wire is_store = OP == `FZE_OP_STORE || OP == `FZE_OP_STOREP;
	wire is_rdiv  = OP == `FZE_OP_RDIV || OP == `FZE_OP_RDIVP ||
		OP == `FZE_OP_IRDIV;

	// Divisor is B, except reverse forms divide B by A
	wire divisor_zero  = is_rdiv ? A_ZERO : B_ZERO;
	wire dividend_ok   = is_rdiv ? (B_FINITE & ~B_ZERO)
		: (A_FINITE & ~A_ZERO);
	// Log and extract take their zero in operand A
	wire zd_div  = is_div(OP) & divisor_zero & dividend_ok;
	wire zd_log  = OP == `FZE_OP_LOG & A_ZERO & B_FINITE & ~B_ZERO;
	wire zd_xtr  = OP == `FZE_OP_XTRACT & A_ZERO;
	wire zd_hit  = zd_div | zd_log | zd_xtr;

	wire load_dn = OP == `FZE_OP_LOAD & A_DENORM &
		(DEST_FMT == `FZE_FMT_SGL || DEST_FMT == `FZE_FMT_DBL);
	wire arit_dn = is_arith(OP) & (A_DENORM | B_DENORM);
	wire dn_hit  = load_dn | arit_dn;

	wire ovf_any = (is_arith(OP) | is_store) & ~zd_hit &
		R_EXP > limit_of(DEST_FMT);
	wire int_dst = is_store & DEST_FMT == `FZE_FMT_INT;
	wire ov_hit  = ovf_any & ~int_dst;

	wire ze_mask = CONTROL[`FZE_ZE_BIT];
	wire de_mask = CONTROL[`FZE_DE_BIT];
	wire ov_mask = CONTROL[`FZE_OE_BIT];
	wire [16:0] rebias_exp = R_EXP - `FZE_REBIAS;
	wire still_ovf = rebias_exp > limit_of(`FZE_FMT_EXT);

	wire busy = state != ST_IDLE;

	fze_result u_res (
		.rnd      (CONTROL[11:10]),
		.sign     (R_SIGN),
		.ovf_sign (ovf_sign),
		.ovf_exp  (ovf_exp),
		.ovf_sig  (ovf_sig)
	);

	fze_flags u_flags (
		.clk     (CLK),
		.reset   (RESET),
		.set_de  (state == ST_TRAP && pend_de),
		.set_ze  (state == ST_TRAP && pend_ze),
		.set_oe  (state == ST_TRAP && pend_oe),
		.clr     (FLAG_CLEAR),
		.c1_we   (state == ST_STORE && pend_c1),
		.c1_val  (pend_c1_val),
		.status  (STATUS)
	);

	always @* begin
		case (state)
		ST_IDLE:  next_state = (START && (zd_hit | dn_hit | ov_hit))
			? ST_STORE : ST_IDLE;
		ST_STORE: next_state = ST_TRAP;
		ST_TRAP:  next_state = ST_IDLE;
		default:  next_state = ST_IDLE;
		endcase
	end

	always @(posedge CLK) begin
		if (RESET) begin
			state           <= ST_IDLE;
			pend_ze         <= 1'b0;
			pend_de         <= 1'b0;
			pend_oe         <= 1'b0;
			pend_c1         <= 1'b0;
			pend_c1_val     <= 1'b0;
			DONE            <= 1'b0;
			TRAP            <= 1'b0;
			INVALID_OPERAND <= 1'b0;
			NORMALIZE       <= 1'b0;
			WRITE_TOP       <= 1'b0;
			WRITE_SECOND    <= 1'b0;
			TOP_SIGN        <= 1'b0;
			TOP_EXP         <= 15'h0000;
			TOP_SIG         <= 64'h0000000000000000;
			SECOND_SIGN     <= 1'b0;
			SECOND_EXP      <= 15'h0000;
			SECOND_SIG      <= 64'h0000000000000000;
		end else begin
			state           <= next_state;
			DONE            <= 1'b0;
			TRAP            <= 1'b0;
			INVALID_OPERAND <= 1'b0;
			NORMALIZE       <= 1'b0;
			WRITE_TOP       <= 1'b0;
			WRITE_SECOND    <= 1'b0;
			if (state == ST_IDLE && START) begin
				INVALID_OPERAND <= ovf_any & int_dst;
				// Masked denormal carries on; denormal loads and masked arithmetic normalize input
				NORMALIZE <= load_dn | (arit_dn & de_mask);
				pend_ze <= zd_hit;
				pend_de <= dn_hit;
				pend_oe <= ov_hit;
				pend_c1 <= 1'b0;
				pend_c1_val <= 1'b0;
				if (!(zd_hit | dn_hit | ov_hit))
					DONE <= 1'b1;
				if (dn_hit && !de_mask) begin
					// Trap before any write; stack untouched
				end else if (zd_hit && ze_mask) begin
					WRITE_TOP <= 1'b1;
					TOP_EXP   <= `FZE_EXP_INF;
					TOP_SIG   <= `FZE_SIG_INF;
					if (zd_div)
						TOP_SIGN <= A_SIGN ^ B_SIGN;
					else if (zd_log)
						TOP_SIGN <= ~B_SIGN;
					else begin
						TOP_SIGN     <= A_SIGN;
						TOP_EXP      <= 15'h0000;
						TOP_SIG      <= 64'h0000000000000000;
						WRITE_SECOND <= 1'b1;
						SECOND_SIGN  <= 1'b1;
						SECOND_EXP   <= `FZE_EXP_INF;
						SECOND_SIG   <= `FZE_SIG_INF;
					end
				end else if (ov_hit && ov_mask) begin
					WRITE_TOP <= 1'b1;
					TOP_SIGN  <= ovf_sign;
					TOP_EXP   <= ovf_exp;
					TOP_SIG   <= ovf_sig;
				end else if (ov_hit && !DEST_MEM && !zd_hit) begin
					WRITE_TOP <= 1'b1;
					TOP_SIGN  <= R_SIGN;
					if (OP == `FZE_OP_SCALE && still_ovf) begin
						TOP_EXP <= `FZE_EXP_INF;
						TOP_SIG <= `FZE_SIG_INF;
					end else begin
						TOP_EXP <= rebias_exp[14:0];
						TOP_SIG <= R_SIG;
					end
					pend_c1     <= 1'b1;
					pend_c1_val <= R_ROUNDED_UP;
				end
				// Unmasked memory overflow writes nothing
			end
			if (state == ST_TRAP) begin
				// Flags set after any store; trap if unmasked
				TRAP <= (pend_ze & ~ze_mask) | (pend_de & ~de_mask)
					| (pend_oe & ~ov_mask);
				DONE <= 1'b1;
			end
		end
	end

endmodule // fze_unit

// file: tb/fze_dp_model.sv
// Far side: register stack and exception dispatch of the datapath.
// Records writes and signals seen since the last clear pulse.
`timescale 1ns/1ps

module fze_dp_model (
	input  wire        clk,
	input  wire        clr,
	input  wire        trap,
	input  wire        inv,
	input  wire        norm,
	input  wire        wr_top,
	input  wire        wr_sec,
	input  wire [79:0] top_in,
	input  wire [79:0] sec_in,
	output reg  [4:0]  seen,
	output reg  [79:0] top_v,
	output reg  [79:0] sec_v
);
	always @(posedge clk) begin
		seen <= (clr ? 5'h00 : seen) | {trap, inv, norm, wr_top, wr_sec};
		if (wr_top) begin
			top_v <= top_in;
		end
		if (wr_sec) begin
			sec_v <= sec_in;
		end
	end
endmodule // fze_dp_model

// file: tb/fze_unit_sva.sv
// Checker for the exception unit, bound to its top-level ports.
// Needs fze_defs.vh on the include path.
`timescale 1ns/1ps
`include "fze_defs.vh"

module fze_unit_sva (
	input wire        CLK,
	input wire        RESET,
	input wire        START,
	input wire [3:0]  OP,
	input wire [1:0]  DEST_FMT,
	input wire        DEST_MEM,
	input wire [15:0] CONTROL,
	input wire [2:0]  FLAG_CLEAR,
	input wire [16:0] R_EXP,
	input wire        DONE,
	input wire        TRAP,
	input wire        INVALID_OPERAND,
	input wire        WRITE_TOP,
	input wire [14:0] TOP_EXP,
	input wire [15:0] STATUS
);
	reg        rb;
	reg [16:0] rbx;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// Unmasked register overflow that still fits after rebias
	always @(posedge CLK) begin
		rb  <= START && OP == `FZE_OP_ARITH && !DEST_MEM && !CONTROL[3]
			&& DEST_FMT == `FZE_FMT_EXT && R_EXP > `FZE_LIM_EXT
			&& R_EXP < 17'h0dfff;
		rbx <= R_EXP - `FZE_REBIAS;
	end

	a_trap_done: assert property (TRAP |-> DONE)
		else $error("trap raised without done");
	a_store_first: assert property (WRITE_TOP |-> ##2 DONE)
		else $error("write not followed by done two cycles later");
	a_status_rsvd: assert property ((STATUS & 16'hfdf1) == 16'h0000)
		else $error("status bit outside the defined set");
	a_flag_sticky: assert property (1 |=>
		(~STATUS[3:1] & $past(STATUS[3:1] & ~FLAG_CLEAR)) == 3'h0)
		else $error("flag dropped without clear");
	a_ze_cause: assert property ($rose(STATUS[2]) |-> $past(START, 3)
		&& $past(OP, 3) >= `FZE_OP_DIV && $past(OP, 3) <= `FZE_OP_XTRACT)
		else $error("zero-divide flag from a non-dividing request");
	a_ov_cause: assert property ($rose(STATUS[3]) |-> $past(START, 3)
		&& $past(R_EXP, 3) > `FZE_LIM_SGL)
		else $error("overflow flag without an out-of-range result");
	a_rebias_exp: assert property (WRITE_TOP && rb |->
		TOP_EXP == rbx[14:0])
		else $error("rebiased exponent wrong");
	a_int_store: assert property (INVALID_OPERAND |->
		!TRAP && !WRITE_TOP && !$rose(STATUS[3]))
		else $error("integer store overflow reported as overflow");

	c_rebias: cover property (WRITE_TOP && rb);
	c_invalid: cover property (INVALID_OPERAND);
	c_trap: cover property (TRAP);
endmodule // fze_unit_sva

bind fze_unit fze_unit_sva chk_u (.CLK(CLK), .RESET(RESET), .START(START),
	.OP(OP), .DEST_FMT(DEST_FMT), .DEST_MEM(DEST_MEM), .CONTROL(CONTROL),
	.FLAG_CLEAR(FLAG_CLEAR), .R_EXP(R_EXP), .DONE(DONE), .TRAP(TRAP),
	.INVALID_OPERAND(INVALID_OPERAND), .WRITE_TOP(WRITE_TOP),
	.TOP_EXP(TOP_EXP), .STATUS(STATUS));

// file: tb/test_fze_unit.sv
// Self-checking bench for the exception unit.
// Drives classified requests; the far-side model captures the results.
`timescale 1ns/1ps
`include "fze_defs.vh"

module test_fze_unit;
	reg         clk = 0, rst = 1, start = 0, mem = 0, rs = 0, rup = 0;
	reg  [3:0]  op = 0, a = 4'h2, b = 4'h2;
	reg  [1:0]  fmt = 0;
	reg  [15:0] ctl = 16'h000e;
	reg  [2:0]  fcl = 0;
	reg  [16:0] rx = 17'h03fff, ex;
	reg  [63:0] rg = 64'hc000000000000001;
	reg         clr = 0;
	wire        done, trap, inv, norm, wt, ws, ts, ss;
	wire [14:0] te, se;
	wire [63:0] tg, sg;
	wire [15:0] st;
	wire [4:0]  seen;
	wire [79:0] tv, sv;
	integer     err_count = 0, checks_done = 0, i;
	localparam [78:0] inf_v = {`FZE_EXP_INF, `FZE_SIG_INF};
	localparam [78:0] max_v = {15'h7ffe, `FZE_SIG_MAXFIN};

	fze_unit dut_u (.CLK(clk), .RESET(rst), .START(start), .OP(op),
		.DEST_FMT(fmt), .DEST_MEM(mem), .CONTROL(ctl), .FLAG_CLEAR(fcl),
		.A_SIGN(a[3]), .A_ZERO(a[2]), .A_FINITE(a[1]), .A_DENORM(a[0]),
		.B_SIGN(b[3]), .B_ZERO(b[2]), .B_FINITE(b[1]), .B_DENORM(b[0]),
		.R_SIGN(rs), .R_EXP(rx), .R_SIG(rg), .R_ROUNDED_UP(rup),
		.DONE(done), .TRAP(trap), .INVALID_OPERAND(inv), .NORMALIZE(norm),
		.WRITE_TOP(wt), .WRITE_SECOND(ws), .TOP_SIGN(ts), .TOP_EXP(te),
		.TOP_SIG(tg), .SECOND_SIGN(ss), .SECOND_EXP(se), .SECOND_SIG(sg),
		.STATUS(st));
	fze_dp_model dp_u (.clk(clk), .clr(clr), .trap(trap), .inv(inv),
		.norm(norm), .wr_top(wt), .wr_sec(ws), .top_in({ts, te, tg}),
		.sec_in({ss, se, sg}), .seen(seen), .top_v(tv), .sec_v(sv));

	always #12.5 clk = ~clk;

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	task chkv(input [8*5:1] n, input [79:0] e, input [79:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", n, e, g);
			end
		end
	endtask

	task chk(input [8*5:1] n, input e, input g);
		begin
			chkv(n, {79'h0, e}, {79'h0, g});
		end
	endtask

	// Clear all sticky flags
	task clear;
		begin
			@(posedge clk) fcl <= 3'h7;
			@(posedge clk) fcl <= 3'h0;
		end
	endtask

	// One request; returns on a clock edge once the unit is idle again
	task go(input [3:0] o, input [3:0] av, input [3:0] bv);
		integer k;
		begin
			@(posedge clk);
			start <= 1'b1;
			op <= o;
			a <= av;
			b <= bv;
			clr <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			clr <= 1'b0;
			k = 0;
			#1;
			while (done !== 1'b1 && inv !== 1'b1 && k < 8) begin
				@(posedge clk);
				#1;
				k = k + 1;
			end
			chk("compl", 1'b1, k < 8);
			repeat (3) @(posedge clk);
		end
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (i = 1; i < 7; i = i + 1) begin
			clear;
			go(i[3:0], (i == 3 || i > 3 && i != 5) ? 4'he : 4'ha,
				(i == 3 || i > 3 && i != 5) ? 4'h2 : 4'h6);
			chk("ze", 1'b1, st[2]);
			chk("trap", 1'b0, seen[4]);
			chkv("top", {1'b1, inf_v}, tv);
		end
		go(`FZE_OP_ARITH, 4'ha, 4'h2);
		chk("ze", 1'b1, st[2]);
		clear;
		go(`FZE_OP_ARITH, 4'ha, 4'h6);
		chk("ze", 1'b0, st[2]);
		go(`FZE_OP_DIV, 4'h8, 4'h6);
		chk("ze", 1'b0, st[2]);
		go(`FZE_OP_LOG, 4'h6, 4'ha);
		chkv("top", {1'b0, inf_v}, tv);
		go(`FZE_OP_XTRACT, 4'he, 4'h2);
		chkv("sec", {1'b1, inf_v}, sv);
		chkv("top", {1'b1, 79'h0}, tv);
		ctl <= 16'h0000;
		clear;
		go(`FZE_OP_DIV, 4'ha, 4'h6);
		chk("trap", 1'b1, seen[4]);
		chk("wr", 1'b0, seen[1]);
		chk("ze", 1'b1, st[2]);
		$display("zero-divide tests done");
		ctl <= 16'h000e;
		clear;
		go(`FZE_OP_ARITH, 4'h3, 4'h2);
		chk("de", 1'b1, st[1]);
		chk("norm", 1'b1, seen[2]);
		chk("trap", 1'b0, seen[4]);
		for (i = 0; i < 3; i = i + 1) begin
			fmt <= i[1:0];
			clear;
			go(`FZE_OP_LOAD, 4'h3, 4'h2);
			chk("de", i != 0, st[1]);
		end
		ctl <= 16'h0000;
		fmt <= `FZE_FMT_EXT;
		clear;
		go(`FZE_OP_ARITH, 4'h3, 4'h2);
		chk("trap", 1'b1, seen[4]);
		chk("wr", 1'b0, seen[1]);
		chk("de", 1'b1, st[1]);
		$display("denormal tests done");
		rx <= 17'h07fff;
		for (i = 0; i < 8; i = i + 1) begin
			ctl <= {4'h0, i[2:1], 10'h00e};
			rs <= i[0];
			clear;
			go(`FZE_OP_ARITH, 4'h2, 4'h2);
			chkv("top", {i[0], (i < 2 || i == 3 || i == 4) ? inf_v : max_v},
				tv);
			chk("oe", 1'b1, st[3]);
		end
		for (i = 0; i < 6; i = i + 1) begin
			fmt <= i[2:1];
			mem <= i[2] | i[1];
			rx <= (i < 2 ? `FZE_LIM_EXT : i < 4 ? `FZE_LIM_SGL : `FZE_LIM_DBL)
				+ {16'h0000, i[0]};
			clear;
			go(i < 2 ? `FZE_OP_ARITH : `FZE_OP_STORE, 4'h2, 4'h2);
			chk("oe", i[0], st[3]);
		end
		fmt <= `FZE_FMT_INT;
		rx <= 17'h1ffff;
		clear;
		go(`FZE_OP_STORE, 4'h2, 4'h2);
		chk("inv", 1'b1, seen[3]);
		chk("oe", 1'b0, st[3]);
		ctl <= 16'h0000;
		fmt <= `FZE_FMT_SGL;
		rx <= 17'h0407f;
		clear;
		go(`FZE_OP_STORE, 4'h2, 4'h2);
		chk("trap", 1'b1, seen[4]);
		chk("wr", 1'b0, seen[1]);
		chk("oe", 1'b1, st[3]);
		mem <= 1'b0;
		fmt <= `FZE_FMT_EXT;
		rx <= 17'h08000;
		for (i = 0; i < 2; i = i + 1) begin
			// Set first, then clear, so a stuck round-up bit shows
			rup <= ~i[0];
			rs <= i[0];
			clear;
			go(`FZE_OP_ARITH, 4'h2, 4'h2);
			ex = rx - 17'd24576;
			chkv("top", {i[0], ex[14:0], rg}, tv);
			chk("c1", ~i[0], st[9]);
			chk("trap", 1'b1, seen[4]);
		end
		rx <= 17'h1ffff;
		rs <= 1'b1;
		clear;
		go(`FZE_OP_SCALE, 4'h2, 4'h2);
		chkv("top", {1'b1, inf_v}, tv);
		$display("overflow tests done");
		report_and_stop;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_count = err_count + 1;
		report_and_stop;
	end
endmodule // test_fze_unit
